// ==== dv/asl_host.sv ====
`timescale 1ns/1ps
module asl_host (
    // Clock and serial pins
    input  wire logic clk,
    input  wire logic idle_hi,
    output logic      sck,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo
);
    // Mode 1,1: clock idles high, nothing selected
    initial
    begin
        sck = 1'b1;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // One control byte, then whole words; slow edges suit the 2FF sync
    task automatic xfer(input logic [7:0] c, input int nw, input logic [23:0] wd,
                        output logic [23:0] rd);
        int i;
        // Settle the idle level first; it picks the mode at chip select fall
        @(posedge clk) sck <= idle_hi;
        repeat (3) @(posedge clk);
        cs_n <= 1'b0;
        for (i = 0; i < 8 + 24 * nw; i++)
        begin
            repeat (5) @(posedge clk);
            sck <= 1'b0;
            sdi <= (i < 8) ? c[7 - i] : wd[23 - (i - 8) % 24];
            repeat (5) @(posedge clk);
            sck <= 1'b1;
            rd = {rd[22:0], sdo};
            // Gap after the control byte lets the first fetch land
            if (i == 7)
                repeat (20) @(posedge clk);
        end
        repeat (5) @(posedge clk);
        // Mode 0,0 ends on a fall and keeps select through a data-ready
        sck <= idle_hi;
        repeat (idle_hi ? 5 : 50) @(posedge clk);
        cs_n <= 1'b1;
        sdi <= ~sdi;
        repeat (10) @(posedge clk);
    endtask
endmodule

// ==== dv/test_asl_spi_seq.sv ====
`timescale 1ns/1ps
module test_asl_spi_seq;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        hard_n = 1'b1, idle_drv = 1'b1, crc_flag = 1'b0, wloop = 1'b1;
    logic [1:0]  rloop = 2'h2;
    logic [7:0]  lock = 8'ha5;
    logic [6:0]  cfg = 7'h30;
    logic [23:0] rdata = 24'h0, wlast, word, wdata;
    logic [4:0]  addr;
    logic [3:0]  restart;
    logic        sck, cs_n, sdi, sdo_pin, sdo_oe, rdy_n, rdy_oe, clear, wr, rd_s, sdo_line;
    logic        latch, host_idle = 1'b1;
    logic [4:0]  wq[$], rq[$];
    int miscompares = 0, total_checks = 0, hits = 0, restarts = 0, lows = 0;

    // Clock and reset
    always #10 clock = ~clock;
    initial
    begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
    end
    // Released data line shows the inverse of the last driven bit
    assign sdo_line = sdo_oe ? sdo_pin : ~sdo_pin;

    asl_host asl_host_inst (.clk(clock), .idle_hi(host_idle), .sck(sck), .cs_n(cs_n),
        .sdi(sdi), .sdo(sdo_line));

    asl_spi_seq #(.SETTLE_CYCLES(20)) asl_spi_seq_inst (
        .CLOCK(clock), .RESET(reset), .SCK(sck), .CS_N(cs_n), .SDI(sdi), .SDO(sdo_pin),
        .SDO_OE(sdo_oe), .DATA_READY_N(rdy_n), .DATA_READY_OE(rdy_oe),
        .HARD_RESET_N(hard_n), .DEVICE_ADDR(2'h1), .READ_LOOP(rloop), .WRITE_LOOP(wloop),
        .LOCK_KEY(lock), .READY_IDLE_DRIVE(idle_drv), .CHECKSUM_FLAG(crc_flag),
        .OVERSAMPLE_RATIO(cfg[6:4]), .PRESCALE(cfg[3:2]), .EXTERNAL_CLOCK_SEL(cfg[1]),
        .EXTERNAL_REF_SEL(cfg[0]), .CONV_ACTIVE(4'h5), .PHASE_DELAY(24'h0),
        .RATE_PERIOD(24'h28), .CONV_RESTART(restart), .CONV_CLEAR(clear),
        .DATA_LATCH(latch), .REG_ADDR(addr), .REG_RD(rd_s), .REG_RDATA(rdata), .REG_WR(wr),
        .REG_WDATA(wdata));

    // Register map stand-in; bit 23 follows the address so neighbours differ
    always @(posedge clock)
        rdata <= {addr[0], 2'h1, addr, 16'hc3a1};

    // Event logs on the falling clock, clear of the stimulus edge
    always @(negedge clock)
    begin
        if (wr === 1'b1)
        begin
            wq.push_back(addr);
            wlast = wdata;
        end
        if (rd_s === 1'b1)
            rq.push_back(addr);
        if (sdo_oe === 1'b1)
            hits++;
        if (restart === 4'h5 && clear === 1'b1)
            restarts++;
        if (rdy_n !== 1'b1)
            lows++;
    end

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask

    task automatic wr_case(input logic [4:0] a, input int nw, input int n,
                           input logic [4:0] e0, e1, e2);
        logic [4:0] e[3];
        e = '{e0, e1, e2};
        wq = {};
        hits = 0;
        asl_host_inst.xfer({2'h1, a, 1'b0}, nw, 24'h3c5a96, word);
        chk("write count", n, wq.size());
        chk("sdo enable in write", 0, hits);
        for (int k = 0; k < n; k++)
            chk("write address", e[k], wq[k]);
        if (n > 0)
            chk("write data", 24'h3c5a96, wlast);
    endtask

    task automatic rd_case(input logic [1:0] m, input logic [4:0] a, e1, e2);
        rloop <= m;
        rq = {};
        wq = {};
        asl_host_inst.xfer({2'h1, a, 1'b1}, 2, 24'h3c5a96, word);
        chk("read address", a, rq[0]);
        chk("second address", e1, rq[1]);
        chk("third address", e2, rq[2]);
        chk("read word", {e1[0], 2'h1, e1, 16'hc3a1}, word);
        chk("writes in read", 0, wq.size());
    endtask

    // Width and spacing of the ready pulses, sampled on the clock
    task automatic dr_case;
        int n;
        logic lat;
        n = 0;
        while (rdy_n !== 1'b0)
            @(posedge clock);
        while (rdy_n === 1'b0)
        begin
            @(posedge clock);
            n++;
        end
        chk("ready low cycles", 7, n);
        n = 0;
        while (rdy_n !== 1'b0)
        begin
            lat = latch;
            @(posedge clock);
            n++;
        end
        chk("ready gap cycles", 33, n);
        chk("latch before pin", 1'b1, lat);
    endtask

    // Mode 0,0 tail: old MSB after the last fall, new MSB at data-ready
    task automatic m0_case;
        host_idle <= 1'b0;
        rloop <= 2'h3;
        hard_n <= 1'b0;
        fork
            asl_host_inst.xfer(8'h61, 1, 24'h0, word);
            begin
                // Start fall, 31 in the frame, then the closing fall
                repeat (33) @(negedge sck);
                repeat (6) @(posedge clock);
                chk("mode 0 tail msb", 1'b0, sdo_line);
                hard_n <= 1'b1;
                @(negedge rdy_n);
                @(posedge clock);
                chk("mode 0 next msb", 1'b1, sdo_line);
            end
        join
        chk("mode 0 word", {1'b0, 2'h1, 5'h10, 16'hc3a1}, word);
    endtask

    task automatic end_sim;
        if (miscompares == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog: whole sequence needs well under 20k cycles
    initial
    begin
        #(20 * 40000);
        miscompares++;
        end_sim;
    end

    initial
    begin
        repeat (12) @(posedge clock);
        chk("idle pins", 3'b011, {sdo_oe, rdy_oe, rdy_n});
        fork
            asl_host_inst.xfer(8'h61, 1, 24'h0, word);
            dr_case;
        join
        wr_case(5'h1e, 3, 3, 5'h1e, 5'h1f, 5'h08);
        wloop <= 1'b0;
        wr_case(5'h09, 2, 2, 5'h09, 5'h09, 5'h00);
        wr_case(5'h03, 1, 0, 5'h00, 5'h00, 5'h00);
        lock <= 8'h00;
        wr_case(5'h09, 1, 0, 5'h00, 5'h00, 5'h00);
        wr_case(5'h1f, 1, 1, 5'h1f, 5'h00, 5'h00);
        lock <= 8'ha5;
        rd_case(2'h0, 5'h05, 5'h05, 5'h05);
        rd_case(2'h1, 5'h06, 5'h07, 5'h04);
        rd_case(2'h2, 5'h06, 5'h07, 5'h00);
        rd_case(2'h3, 5'h1e, 5'h1f, 5'h00);
        rq = {};
        asl_host_inst.xfer(8'h83, 1, 24'h0, word);
        chk("foreign reads", 0, rq.size());
        m0_case;
        restarts = 0;
        for (int k = 0; k < 7; k++)
        begin
            cfg <= cfg ^ (7'h01 << k);
            repeat (10) @(posedge clock);
        end
        chk("setting restarts", 7, restarts);
        wr_case(5'h0a, 1, 1, 5'h0a, 5'h00, 5'h00);
        chk("phase restarts", 8, restarts);
        crc_flag <= 1'b1;
        repeat (3) @(posedge clock);
        lows = 0;
        repeat (60) @(posedge clock);
        chk("ready under checksum", 60, lows);
        crc_flag <= 1'b0;
        hard_n <= 1'b0;
        idle_drv <= 1'b0;
        repeat (5) @(posedge clock);
        lows = 0;
        repeat (60) @(posedge clock);
        chk("ready in hard reset", 2'b00, {rdy_oe, lows[0]});
        chk("ready low count", 0, lows);
        idle_drv <= 1'b1;
        repeat (3) @(posedge clock);
        chk("ready idle drive", 2'b11, {rdy_oe, rdy_n});
        end_sim;
    end
endmodule

// ==== hw/asl_buf2.sv ====
`timescale 1ns/1ps
module asl_buf2
    import asl_pkg::*;
(
    // System
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              flush,
    // Filling side
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire logic [WORD_W-1:0] in_data,
    // Draining side
    output logic                   out_valid,
    input  wire logic              out_ready,
    output logic [WORD_W-1:0]      out_data
);

    logic [WORD_W-1:0] mem_r [BUF_DEPTH];
    logic              wr_idx_r;
    logic              rd_idx_r;
    logic [1:0]        cnt_r;
    logic              push;
    logic              pop;

    // Handshakes; a full buffer refuses the source
    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rd_idx_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage
    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wr_idx_r] <= in_data;
    end

    // Pointers and fill count; flush drops everything
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_idx_r <= 1'b0;
            rd_idx_r <= 1'b0;
            cnt_r    <= 2'h0;
        end
        else if (flush)
        begin
            wr_idx_r <= 1'b0;
            rd_idx_r <= 1'b0;
            cnt_r    <= 2'h0;
        end
        else
        begin
            if (push)
                wr_idx_r <= ~wr_idx_r;
            if (pop)
                rd_idx_r <= ~rd_idx_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule

// ==== hw/asl_spi_seq.sv ====
`timescale 1ns/1ps
// Functional notes
// - One control byte after chip select falls; same loop until chip select rises.
// - Pointer starts at control byte address, advances inside the selected set.
// - At the set's last address the pointer wraps to its first address.
// - Read loop: 00 static, 01 groups, 10 types, 11 whole map.
// - Serial input is ignored after the control byte of a read.
// - Mode 0,0: old MSB at last falling edge, new MSB at data-ready.
// - Mode 1,1: serial output holds the previous word's LSB after reading.
// - Write loop: 0 static, 1 loop over type sets.
// - Serial output stays high-impedance throughout a write.
// - Writes to non-writable addresses change nothing and keep the pointer.
// - Lock key not 0xA5 blocks writes to all but 0x1F.
// - Phase write or converter setting change restarts active converters.
// - Restart clears converter outputs; conversion resumes by itself.
// - Data-ready pulses low for half a modulator clock period.
// - First pulse after settling plus phase delay, then every rate period.
// - Idle data-ready floats when idle-drive is 0, drives high when 1.
// - Data-ready pulses run regardless of chip select.
// - Hard reset pin low keeps data-ready inactive.
// - Checksum interrupt flag holds data-ready low.
// - Converter data updates one clock before the data-ready pin goes low.
// - Control byte: device address 7:6, register address 5:1, read flag 0.
// - Chip select rising aborts the transfer and returns to idle.
// - Output changes on falling serial clock, input sampled on rising.
module asl_spi_seq
    import asl_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEF
)
(
    // System
    input  wire logic                 CLOCK,
    input  wire logic                 RESET,
    // Serial pins
    input  wire logic                 SCK,
    input  wire logic                 CS_N,
    input  wire logic                 SDI,
    output logic                      SDO,
    output logic                      SDO_OE,
    // Data-ready pin and hard reset pin
    output logic                      DATA_READY_N,
    output logic                      DATA_READY_OE,
    input  wire logic                 HARD_RESET_N,
    // Loop, lock and pin settings
    input  wire logic [1:0]           DEVICE_ADDR,
    input  wire logic [1:0]           READ_LOOP,
    input  wire logic                 WRITE_LOOP,
    input  wire logic [7:0]           LOCK_KEY,
    input  wire logic                 READY_IDLE_DRIVE,
    input  wire logic                 CHECKSUM_FLAG,
    // Converter settings and control
    input  wire logic [2:0]           OVERSAMPLE_RATIO,
    input  wire logic [1:0]           PRESCALE,
    input  wire logic                 EXTERNAL_CLOCK_SEL,
    input  wire logic                 EXTERNAL_REF_SEL,
    input  wire logic [3:0]           CONV_ACTIVE,
    input  wire logic [RDY_CNT_W-1:0] PHASE_DELAY,
    input  wire logic [RDY_CNT_W-1:0] RATE_PERIOD,
    output logic [3:0]                CONV_RESTART,
    output logic                      CONV_CLEAR,
    output logic                      DATA_LATCH,
    // Register map access
    output logic [4:0]                REG_ADDR,
    output logic                      REG_RD,
    input  wire logic [WORD_W-1:0]    REG_RDATA,
    output logic                      REG_WR,
    output logic [WORD_W-1:0]         REG_WDATA
);

    typedef enum logic [2:0] {ST_IDLE, ST_CTRL, ST_READ, ST_WRITE, ST_SKIP} asl_state_t;

    asl_state_t            st_r;
    logic                  sck_s1, sck_s2, sck_d;
    logic                  cs_s1, cs_s2, cs_d;
    logic                  sdi_s1, sdi_s2;
    logic                  hrst_s1, hrst_s2;
    logic                  sck_rise, sck_fall, cs_fall;
    logic                  cpol_r;
    logic [4:0]            bit_cnt_r;
    logic [7:0]            ctrl_sh_r;
    logic [7:0]            ctrl_byte;
    logic                  ctrl_done;
    logic [4:0]            ptr_r;
    logic [4:0]            rd_first, rd_last;
    logic                  wr_done, wr_ok;
    logic [1:0]            wr_mode;
    logic [WORD_W-1:0]     in_sh_r;
    logic [WORD_W-1:0]     out_sh_r;
    logic                  first_r, hold_msb_r, last_msb_r;
    logic                  rd_edge, pop, push, pend_r;
    logic                  buf_in_ready, buf_valid;
    logic [WORD_W-1:0]     buf_data, head;
    logic [6:0]            cfg_now, cfg_q_r;
    logic                  cfg_vld_r, restart;
    logic [RDY_CNT_W-1:0]  rdy_cnt_r;
    logic [3:0]            pulse_cnt_r;
    logic                  rdy_fire;

    // Bounds {first, last} of the loop set holding addr
    function automatic logic [9:0] set_span(input logic [4:0] addr, input logic [1:0] mode);
        logic [9:0] span;
        span = {addr, addr};
        unique case (mode)
            LOOP_STATIC: span = {addr, addr};
            LOOP_GROUP:  span = {addr & GROUP_MASK, addr | ~GROUP_MASK};
            LOOP_TYPE:   span = (addr < TYPE_SPLIT) ? {5'h00, TYPE_SPLIT - 5'h01}
                                                    : {TYPE_SPLIT, LAST_ADDR};
            LOOP_FULL:   span = {5'h00, LAST_ADDR};
        endcase
        return span;
    endfunction

    // Next pointer: step up, wrap from the set's last address to its first
    function automatic logic [4:0] next_addr(input logic [4:0] addr, input logic [1:0] mode);
        logic [9:0] span;
        span = set_span(addr, mode);
        return (addr == span[4:0]) ? span[9:5] : addr + 5'h01;
    endfunction

    // Pin synchronisers; SCK must stay below a quarter of CLOCK
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            sck_s1  <= 1'b0;
            sck_s2  <= 1'b0;
            sck_d   <= 1'b0;
            cs_s1   <= 1'b1;
            cs_s2   <= 1'b1;
            cs_d    <= 1'b1;
            sdi_s1  <= 1'b0;
            sdi_s2  <= 1'b0;
            hrst_s1 <= 1'b0;
            hrst_s2 <= 1'b0;
        end
        else
        begin
            sck_s1  <= SCK;
            sck_s2  <= sck_s1;
            sck_d   <= sck_s2;
            cs_s1   <= CS_N;
            cs_s2   <= cs_s1;
            cs_d    <= cs_s2;
            sdi_s1  <= SDI;
            sdi_s2  <= sdi_s1;
            hrst_s1 <= HARD_RESET_N;
            hrst_s2 <= hrst_s1;
        end
    end

    // Edge and decode terms
    assign sck_rise  = sck_s2 & ~sck_d;
    assign sck_fall  = ~sck_s2 & sck_d;
    assign cs_fall   = ~cs_s2 & cs_d;
    assign ctrl_byte = {ctrl_sh_r[6:0], sdi_s2};
    assign ctrl_done = (st_r == ST_CTRL) && sck_rise && (bit_cnt_r == CTRL_LAST);
    assign wr_done   = (st_r == ST_WRITE) && sck_rise && (bit_cnt_r == WORD_LAST);
    assign wr_ok     = (ptr_r >= FIRST_WRITABLE)
                       && ((LOCK_KEY == LOCK_OPEN) || (ptr_r == LAST_ADDR));
    assign wr_mode   = WRITE_LOOP ? LOOP_TYPE : LOOP_STATIC;
    assign rd_edge   = (st_r == ST_READ) && sck_fall;
    assign head      = buf_valid ? buf_data : '0;
    assign pop       = (rd_edge && (bit_cnt_r == 5'h00) && (first_r || cpol_r))
                       || ((st_r == ST_READ) && hold_msb_r && sck_rise);
    assign push      = pend_r && (st_r == ST_READ);
    assign {rd_first, rd_last} = set_span(ptr_r, READ_LOOP);

    // Transfer state; chip select high always returns to idle
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            st_r <= ST_IDLE;
        else if (cs_s2)
            st_r <= ST_IDLE;
        else
        begin
            unique case (st_r)
                ST_IDLE:
                    if (cs_fall)
                        st_r <= ST_CTRL;
                ST_CTRL:
                    if (ctrl_done)
                    begin
                        // Other device addresses share the bus; stay silent
                        if (ctrl_byte[CTRL_DEV_HI:CTRL_DEV_LO] != DEVICE_ADDR)
                            st_r <= ST_SKIP;
                        else if (ctrl_byte[CTRL_RW_BIT])
                            st_r <= ST_READ;
                        else
                            st_r <= ST_WRITE;
                    end
                ST_READ, ST_WRITE, ST_SKIP:
                    st_r <= st_r;
            endcase
        end
    end

    // Bit counting, clock polarity and control byte shift
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            bit_cnt_r <= 5'h00;
            cpol_r    <= 1'b0;
            ctrl_sh_r <= 8'h00;
        end
        else if (st_r == ST_IDLE)
        begin
            bit_cnt_r <= 5'h00;
            if (cs_fall)
                cpol_r <= sck_s2;
        end
        else if (ctrl_done)
            bit_cnt_r <= 5'h00;
        else if ((st_r == ST_CTRL) && sck_rise)
        begin
            ctrl_sh_r <= ctrl_byte;
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
        else if ((st_r == ST_WRITE) && sck_rise)
            bit_cnt_r <= wr_done ? 5'h00 : bit_cnt_r + 5'h01;
        else if (pop)
            bit_cnt_r <= WORD_LAST;
        else if (rd_edge && (bit_cnt_r != 5'h00))
            bit_cnt_r <= bit_cnt_r - 5'h01;
    end

    // Address pointer
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            ptr_r <= 5'h00;
        else if (ctrl_done)
            ptr_r <= ctrl_byte[CTRL_REG_HI:CTRL_REG_LO];
        else if (push)
            ptr_r <= next_addr(ptr_r, READ_LOOP);
        else if (wr_done && wr_ok)
            ptr_r <= next_addr(ptr_r, wr_mode);
    end

    // Write data shift, rising edges only
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            in_sh_r <= '0;
        else if ((st_r == ST_WRITE) && sck_rise)
            in_sh_r <= {in_sh_r[WORD_W-2:0], sdi_s2};
    end

    // Register map port: fetch one word at a time, write on a full word
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            REG_ADDR  <= 5'h00;
            REG_RD    <= 1'b0;
            pend_r    <= 1'b0;
            REG_WR    <= 1'b0;
            REG_WDATA <= '0;
        end
        else
        begin
            REG_ADDR <= ptr_r;
            // A stalled shifter leaves the buffer full and stops fetching
            REG_RD   <= (st_r == ST_READ) && !cs_s2 && !REG_RD && !pend_r && buf_in_ready;
            pend_r   <= REG_RD && !cs_s2;
            REG_WR   <= wr_done && wr_ok;
            if (wr_done)
                REG_WDATA <= {in_sh_r[WORD_W-2:0], sdi_s2};
        end
    end

    // Two-word read buffer between fetch and shifter
    asl_buf2 asl_buf2_inst (
        .clk       (CLOCK),
        .rst       (RESET),
        .flush     (st_r != ST_READ),
        .in_valid  (push),
        .in_ready  (buf_in_ready),
        .in_data   (REG_RDATA),
        .out_valid (buf_valid),
        .out_ready (pop),
        .out_data  (buf_data)
    );

    // Serial output; driven only during the data phase of a read
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            SDO        <= 1'b0;
            SDO_OE     <= 1'b0;
            out_sh_r   <= '0;
            first_r    <= 1'b1;
            hold_msb_r <= 1'b0;
            last_msb_r <= 1'b0;
        end
        else if ((st_r != ST_READ) || cs_s2)
        begin
            SDO_OE     <= 1'b0;
            first_r    <= 1'b1;
            hold_msb_r <= 1'b0;
        end
        else if (rd_edge)
        begin
            SDO_OE <= 1'b1;
            if (bit_cnt_r != 5'h00)
            begin
                SDO      <= out_sh_r[WORD_W-1];
                out_sh_r <= {out_sh_r[WORD_W-2:0], 1'b0};
            end
            else if (first_r || cpol_r)
            begin
                // Mode 1,1 reaches here only at a word start, so LSB holds
                SDO        <= head[WORD_W-1];
                out_sh_r   <= {head[WORD_W-2:0], 1'b0};
                last_msb_r <= head[WORD_W-1];
                first_r    <= 1'b0;
            end
            else
            begin
                SDO        <= last_msb_r;
                hold_msb_r <= 1'b1;
            end
        end
        else if (hold_msb_r && sck_rise)
        begin
            out_sh_r   <= {head[WORD_W-2:0], 1'b0};
            last_msb_r <= head[WORD_W-1];
            hold_msb_r <= 1'b0;
        end
        else if (hold_msb_r && rdy_fire)
            SDO <= head[WORD_W-1];
    end

    // Converter restart on phase write or setting change
    assign cfg_now = {OVERSAMPLE_RATIO, PRESCALE, EXTERNAL_CLOCK_SEL, EXTERNAL_REF_SEL};
    assign restart = (wr_done && wr_ok && (ptr_r == PHASE_ADDR))
                     || (cfg_vld_r && (cfg_now != cfg_q_r));

    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            cfg_q_r      <= 7'h00;
            cfg_vld_r    <= 1'b0;
            CONV_RESTART <= 4'h0;
            CONV_CLEAR   <= 1'b0;
        end
        else
        begin
            cfg_q_r      <= cfg_now;
            cfg_vld_r    <= 1'b1;
            CONV_RESTART <= restart ? CONV_ACTIVE : 4'h0;
            CONV_CLEAR   <= restart;
        end
    end

    // Data-ready timer; free of the serial interface
    assign rdy_fire = hrst_s2 && !restart && (rdy_cnt_r == '0);

    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            rdy_cnt_r <= RDY_CNT_W'(SETTLE_CYCLES);
        else if (!hrst_s2 || restart)
            rdy_cnt_r <= RDY_CNT_W'(SETTLE_CYCLES) + PHASE_DELAY;
        else if (rdy_cnt_r == '0)
            rdy_cnt_r <= RATE_PERIOD - {{(RDY_CNT_W-1){1'b0}}, 1'b1};
        else
            rdy_cnt_r <= rdy_cnt_r - {{(RDY_CNT_W-1){1'b0}}, 1'b1};
    end

    // Pulse width counter
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            pulse_cnt_r <= 4'h0;
        else if (rdy_fire)
            pulse_cnt_r <= RDY_PULSE_CYCLES;
        else if (pulse_cnt_r != 4'h0)
            pulse_cnt_r <= pulse_cnt_r - 4'h1;
    end

    // Data-ready pin drive; checksum alarm outranks pulses
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            DATA_READY_N  <= 1'b1;
            DATA_READY_OE <= 1'b0;
            DATA_LATCH    <= 1'b0;
        end
        else
        begin
            DATA_LATCH <= rdy_fire;
            if (!hrst_s2)
            begin
                DATA_READY_N  <= 1'b1;
                DATA_READY_OE <= READY_IDLE_DRIVE;
            end
            else if (CHECKSUM_FLAG || (pulse_cnt_r != 4'h0))
            begin
                DATA_READY_N  <= 1'b0;
                DATA_READY_OE <= 1'b1;
            end
            else
            begin
                DATA_READY_N  <= 1'b1;
                DATA_READY_OE <= READY_IDLE_DRIVE;
            end
        end
    end

    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);

    a_sdo_write_hiz: assert property ((st_r == ST_WRITE) |-> !SDO_OE)
        else $error("serial output driven during write");
    a_write_gate: assert property (REG_WR |-> (REG_ADDR >= FIRST_WRITABLE)
        && (($past(LOCK_KEY) == LOCK_OPEN) || (REG_ADDR == LAST_ADDR)))
        else $error("write reached a blocked address");
    a_blocked_hold: assert property ((wr_done && !wr_ok) |=> $stable(ptr_r) && !REG_WR)
        else $error("blocked write moved pointer or wrote");
    a_ptr_wrap: assert property ((push && (ptr_r == rd_last))
        |=> (ptr_r == $past(rd_first)))
        else $error("pointer did not wrap to set start");
    a_pulse_width: assert property ($rose(pulse_cnt_r != 4'h0)
        |-> (pulse_cnt_r != 4'h0)[*7] ##1 (pulse_cnt_r == 4'h0))
        else $error("data-ready pulse width wrong");
    a_pulse_pin: assert property ((pulse_cnt_r != 4'h0) && hrst_s2 |=> !DATA_READY_N)
        else $error("pulse not seen on pin");
    a_check_low: assert property (CHECKSUM_FLAG && hrst_s2 |=> !DATA_READY_N && DATA_READY_OE)
        else $error("checksum alarm not held low");
    a_hard_off: assert property (!hrst_s2 |=> DATA_READY_N && (pulse_cnt_r == 4'h0
        || $past(rdy_fire) == 1'b0))
        else $error("data-ready active in hard reset");
    a_idle_drive: assert property ((pulse_cnt_r == 4'h0) && !CHECKSUM_FLAG && hrst_s2
        |=> DATA_READY_N && (DATA_READY_OE == $past(READY_IDLE_DRIVE)))
        else $error("idle data-ready drive wrong");
    a_restart_pulse: assert property ((wr_done && wr_ok && (ptr_r == PHASE_ADDR))
        |=> CONV_CLEAR && (CONV_RESTART == $past(CONV_ACTIVE)) ##1 !CONV_CLEAR
        || restart)
        else $error("phase write did not restart converters");
    a_cs_abort: assert property (cs_s2 |=> (st_r == ST_IDLE) ##1 !SDO_OE)
        else $error("chip select high did not abort");
    a_read_no_sdi: assert property ((st_r == ST_READ) |=> $stable(in_sh_r))
        else $error("serial input taken during read");

endmodule

// ==== inc/asl_pkg.sv ====
package asl_pkg;

    // Word and buffer shape
    localparam int WORD_W    = 24;
    localparam int BUF_DEPTH = 2;

    // Control byte fields
    localparam int CTRL_DEV_HI = 7;
    localparam int CTRL_DEV_LO = 6;
    localparam int CTRL_REG_HI = 5;
    localparam int CTRL_REG_LO = 1;
    localparam int CTRL_RW_BIT = 0;

    // Bit counter end points
    localparam logic [4:0] CTRL_LAST = 5'h07;
    localparam logic [4:0] WORD_LAST = 5'h17;

    // Address map
    localparam logic [4:0] FIRST_WRITABLE = 5'h08;
    localparam logic [4:0] LAST_ADDR      = 5'h1f;
    localparam logic [4:0] PHASE_ADDR     = 5'h0a;
    localparam logic [7:0] LOCK_OPEN      = 8'ha5;

    // Loop set boundaries
    localparam logic [4:0] GROUP_MASK = 5'h1c;
    localparam logic [4:0] TYPE_SPLIT = 5'h08;

    // Loop modes
    localparam logic [1:0] LOOP_STATIC = 2'h0;
    localparam logic [1:0] LOOP_GROUP  = 2'h1;
    localparam logic [1:0] LOOP_TYPE   = 2'h2;
    localparam logic [1:0] LOOP_FULL   = 2'h3;

    // Timing
    localparam int RDY_CNT_W         = 24;
    localparam int CLK_PERIOD_NS     = 20;
    localparam int MOD_CLK_PERIOD_NS = 250;
    localparam int RDY_PULSE_NS      = MOD_CLK_PERIOD_NS / 2;
    localparam logic [3:0] RDY_PULSE_CYCLES =
        4'((RDY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int SETTLE_TIME_NS    = 100000;
    localparam int SETTLE_CYCLES_DEF = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage
